/* rtl/pwm_timer_pkg.sv */
/*
  constants shared by the buffered compare / pwm counter unit:
  register byte offsets, field positions, reset values, prescaler codes
  and the bus answer states.
  assumes a 32-bit avalon-mm slave port with byte addressing.
*/
package pwm_timer_pkg;

  // register byte offsets
  localparam logic [4:0] main_status_control_addr = 5'h00;
  localparam logic [4:0] counter_value_addr       = 5'h04;
  localparam logic [4:0] period_limit_addr        = 5'h08;
  localparam logic [4:0] chan0_status_control_addr = 5'h0c;
  localparam logic [4:0] chan0_compare_addr       = 5'h10;
  localparam logic [4:0] chan1_status_control_addr = 5'h14;
  localparam logic [4:0] chan1_compare_addr       = 5'h18;

  // main status/control fields
  localparam int wrap_flag_pos       = 7;
  localparam int wrap_irq_enable_pos = 6;
  localparam int halt_count_bit_pos  = 5;
  localparam int counter_reset_pos   = 4;
  localparam int prescale_lsb        = 0;
  localparam int prescale_width      = 3;

  // channel status/control fields
  localparam int channel_event_flag_pos = 7;
  localparam int channel_irq_enable_pos = 6;
  localparam int chan_ctrl_width        = 6;
  localparam int mode_select_high_pos   = 5;
  localparam int mode_select_low_pos    = 4;
  localparam int edge_level_high_pos    = 3;
  localparam int edge_level_low_pos     = 2;
  localparam int toggle_on_wrap_pos     = 1;
  localparam int full_duty_pos          = 0;

  // edge/level actions on compare
  localparam logic [1:0] els_toggle = 2'h1;
  localparam logic [1:0] els_clear  = 2'h2;
  localparam logic [1:0] els_set    = 2'h3;

  // reset values
  localparam logic        halt_count_reset   = 1'h1;
  localparam logic [15:0] period_limit_reset = 16'hffff;
  localparam logic [15:0] compare_reset      = 16'h0000;
  localparam logic [15:0] counter_reset      = 16'h0000;
  localparam logic [2:0]  prescale_reset     = 3'h0;

  // prescaler select code that picks the external counter clock pin
  localparam logic [2:0] prescale_external = 3'h7;
  localparam int         prescale_bits     = 6;

  typedef enum logic [1:0] {
    bus_idle   = 2'h1,
    bus_answer = 2'h2
  } bus_state_t;

endpackage

/* rtl/counter_prescaler.sv */
/*
  prescaler for the counter unit: divides the bus clock by 1..64 or
  passes rising edges of the external count pin, as one-cycle ticks.
  assumes ext_clock_pin is already synchronous to clk.
*/
`timescale 1ns/1ps
module counter_prescaler (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [2:0] select,
  input  wire logic       ext_clock_pin,
  output logic            tick
);

  typedef struct packed {
    logic [pwm_timer_pkg::prescale_bits-1:0] div;
    logic                                    ext_prev;
  } prescaler_state_t;

  prescaler_state_t s;
  prescaler_state_t next_s;
  logic [pwm_timer_pkg::prescale_bits-1:0] mask;

  always_comb begin
    next_s = s;
    mask = (pwm_timer_pkg::prescale_bits)'((7'h01 << select) - 7'h01);
    tick = 1'b0;
    next_s.ext_prev = ext_clock_pin;
    if (clear) begin
      next_s.div = '0;
    end else if (run) begin
      if (select == pwm_timer_pkg::prescale_external) begin
        tick = ext_clock_pin & ~s.ext_prev;
      end else begin
        tick = ((s.div & mask) == mask);
        next_s.div = s.div + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* rtl/buffered_compare_pwm_timer.sv */
/*
  16-bit modulo counter unit with two compare channels, buffered
  (linked) compare/pwm, toggle on wrap, full duty, flags and requests.
  assumes an avalon-mm master on the register port and synchronous
  low-power mode inputs from the system controller.
*/
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - link buffer select on channel 0 joins both channels onto channel 0 pin
// - channel 0 compare controls first; last written pair takes over at each wrap
// - toggle-on-wrap flips the pin at each wrap; wraps define the period
// - pulse width runs from wrap to compare match
// - period equals limit plus one prescaled clocks; 255 gives 256
// - compare 128 over an 8-bit period gives half duty
// - a compare value already passed gives no match this period
// - mode select 0:1 unbuffered, 1:0 buffered
// - edge level 1:0 clears the pin, 1:1 sets it on compare
// - toggle-on-wrap cleared stops wrap toggles, giving zero duty
// - full duty bit with toggle-on-wrap clear drives pin always high
// - wrap flag sets on wrap to zero; request when enabled
// - channel flag sets on compare; request only when enabled
// - in wait mode counting goes on, registers closed, requests wake
// - in stop mode the counter, prescaler and pin freeze and resume afterwards; registers stay accessible
// - at the limit value the counter restarts from zero next tick
// - counter reset clears counter and prescaler, self-clears, reads zero
// - flags clear by read-with-flag-set then write zero; new event wins
module buffered_compare_pwm_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        ext_clock_pin,
  output logic             channel_output_pin,
  output logic             channel_output_enable,
  output logic             wrap_irq,
  output logic [1:0]       channel_irq,
  output logic             wake_request
);

  typedef struct packed {
    pwm_timer_pkg::bus_state_t                       bus;
    logic [31:0]                                     rdata;
    logic                                            wrap_flag;
    logic                                            wrap_irq_enable;
    logic                                            wrap_arm;
    logic                                            halt_count_bit;
    logic [2:0]                                      prescale;
    logic [15:0]                                     count;
    logic [15:0]                                     period_limit;
    logic [1:0]                                      event_flag;
    logic [1:0]                                      irq_enable;
    logic [1:0]                                      event_arm;
    logic [1:0][pwm_timer_pkg::chan_ctrl_width-1:0]  ctrl;
    logic [1:0][15:0]                                compare;
    logic                                            active_sel;
    logic                                            last_written;
    logic                                            pin;
    logic                                            pin_out;
    logic                                            pin_en;
    logic                                            wrap_req;
    logic [1:0]                                      chan_req;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  logic        tick;
  logic        taken;
  logic        reg_open;
  logic        wr_lo;
  logic        wr_hi;
  logic        counter_clear;
  logic        counter_run;
  logic        linked;
  logic        wrap;
  logic [15:0] count_next;
  logic [15:0] active_compare;
  logic [1:0]  match;
  logic [1:0]  chan_on;
  logic [1:0]  els;
  logic [31:0] rd_value;

  // the bus answer always comes one cycle after the request appears
  assign waitrequest = (read | write) & (s.bus != pwm_timer_pkg::bus_answer);
  assign taken       = (read | write) & (s.bus == pwm_timer_pkg::bus_answer);
  assign reg_open    = ~wait_mode;
  assign wr_lo       = taken & write & reg_open & byteenable[0];
  assign wr_hi       = taken & write & reg_open & byteenable[1];

  assign counter_clear = wr_lo & (address == pwm_timer_pkg::main_status_control_addr)
                       & writedata[pwm_timer_pkg::counter_reset_pos];
  // a stopped device freezes the prescaler as well as the counter
  assign counter_run = ~s.halt_count_bit & ~stop_mode;

  counter_prescaler prescaler (
    .clk           (clk),
    .rst           (rst),
    .clear         (counter_clear),
    .run           (counter_run),
    .select        (s.prescale),
    .ext_clock_pin (ext_clock_pin),
    .tick          (tick)
  );

  assign linked = s.ctrl[0][pwm_timer_pkg::mode_select_high_pos];

  always_comb begin
    rd_value = 32'h0000_0000;
    if (address == pwm_timer_pkg::main_status_control_addr) begin
      rd_value[pwm_timer_pkg::wrap_flag_pos]       = s.wrap_flag;
      rd_value[pwm_timer_pkg::wrap_irq_enable_pos] = s.wrap_irq_enable;
      rd_value[pwm_timer_pkg::halt_count_bit_pos]  = s.halt_count_bit;
      rd_value[2:0]                                = s.prescale;
    end else if (address == pwm_timer_pkg::counter_value_addr) begin
      rd_value[15:0] = s.count;
    end else if (address == pwm_timer_pkg::period_limit_addr) begin
      rd_value[15:0] = s.period_limit;
    end else if (address == pwm_timer_pkg::chan0_status_control_addr) begin
      rd_value[pwm_timer_pkg::channel_event_flag_pos] = s.event_flag[0];
      rd_value[pwm_timer_pkg::channel_irq_enable_pos] = s.irq_enable[0];
      rd_value[5:0]                                   = s.ctrl[0];
    end else if (address == pwm_timer_pkg::chan0_compare_addr) begin
      rd_value[15:0] = s.compare[0];
    end else if (address == pwm_timer_pkg::chan1_status_control_addr) begin
      rd_value[pwm_timer_pkg::channel_event_flag_pos] = s.event_flag[1];
      rd_value[pwm_timer_pkg::channel_irq_enable_pos] = s.irq_enable[1];
      rd_value[5:0]                                   = s.ctrl[1];
    end else if (address == pwm_timer_pkg::chan1_compare_addr) begin
      rd_value[15:0] = s.compare[1];
    end
    if (!reg_open) begin
      rd_value = 32'h0000_0000;
    end
  end

  always_comb begin
    next_s = s;

    // counting and compare events
    wrap = tick & (s.count == s.period_limit);
    if (wrap) begin
      count_next = 16'h0000;
    end else if (tick) begin
      count_next = s.count + 16'h0001;
    end else begin
      count_next = s.count;
    end
    // a value the counter has already passed cannot match until it comes round
    active_compare = (linked && s.active_sel) ? s.compare[1] : s.compare[0];
    chan_on[0] = s.ctrl[0][pwm_timer_pkg::mode_select_high_pos]
               | s.ctrl[0][pwm_timer_pkg::mode_select_low_pos];
    chan_on[1] = ~linked & (s.ctrl[1][pwm_timer_pkg::mode_select_high_pos]
               | s.ctrl[1][pwm_timer_pkg::mode_select_low_pos]);
    match[0] = tick & chan_on[0] & (count_next == active_compare);
    match[1] = tick & chan_on[1] & (count_next == s.compare[1]);
    els = s.ctrl[0][pwm_timer_pkg::edge_level_low_pos +: 2];

    if (counter_clear) begin
      next_s.count = pwm_timer_pkg::counter_reset;
    end else begin
      next_s.count = count_next;
    end

    // bus handshake and read capture
    if (taken) begin
      next_s.bus = pwm_timer_pkg::bus_idle;
    end else if (read | write) begin
      next_s.bus   = pwm_timer_pkg::bus_answer;
      next_s.rdata = rd_value;
    end

    // arm the two-step flag clear on a read that sees the flag set
    if (taken && read && reg_open) begin
      if (address == pwm_timer_pkg::main_status_control_addr && s.wrap_flag) begin
        next_s.wrap_arm = 1'b1;
      end else if (address == pwm_timer_pkg::chan0_status_control_addr
                   && s.event_flag[0]) begin
        next_s.event_arm[0] = 1'b1;
      end else if (address == pwm_timer_pkg::chan1_status_control_addr
                   && s.event_flag[1]) begin
        next_s.event_arm[1] = 1'b1;
      end
    end

    // register writes
    if (wr_lo) begin
      if (address == pwm_timer_pkg::main_status_control_addr) begin
        next_s.wrap_irq_enable = writedata[pwm_timer_pkg::wrap_irq_enable_pos];
        next_s.halt_count_bit  = writedata[pwm_timer_pkg::halt_count_bit_pos];
        next_s.prescale = writedata[pwm_timer_pkg::prescale_lsb +: pwm_timer_pkg::prescale_width];
        if (s.wrap_arm && !writedata[pwm_timer_pkg::wrap_flag_pos]) begin
          next_s.wrap_flag = 1'b0;
        end
        next_s.wrap_arm = 1'b0;
      end else if (address == pwm_timer_pkg::chan0_status_control_addr) begin
        next_s.irq_enable[0] = writedata[pwm_timer_pkg::channel_irq_enable_pos];
        next_s.ctrl[0]       = writedata[5:0];
        if (s.event_arm[0] && !writedata[pwm_timer_pkg::channel_event_flag_pos]) begin
          next_s.event_flag[0] = 1'b0;
        end
        next_s.event_arm[0] = 1'b0;
      end else if (address == pwm_timer_pkg::chan1_status_control_addr) begin
        next_s.irq_enable[1] = writedata[pwm_timer_pkg::channel_irq_enable_pos];
        next_s.ctrl[1]       = writedata[5:0];
        if (s.event_arm[1] && !writedata[pwm_timer_pkg::channel_event_flag_pos]) begin
          next_s.event_flag[1] = 1'b0;
        end
        next_s.event_arm[1] = 1'b0;
      end else if (address == pwm_timer_pkg::period_limit_addr) begin
        next_s.period_limit[7:0] = writedata[7:0];
      end else if (address == pwm_timer_pkg::chan0_compare_addr) begin
        next_s.compare[0][7:0] = writedata[7:0];
      end else if (address == pwm_timer_pkg::chan1_compare_addr) begin
        next_s.compare[1][7:0] = writedata[7:0];
      end
    end
    if (wr_hi) begin
      if (address == pwm_timer_pkg::period_limit_addr) begin
        next_s.period_limit[15:8] = writedata[15:8];
      end else if (address == pwm_timer_pkg::chan0_compare_addr) begin
        next_s.compare[0][15:8] = writedata[15:8];
      end else if (address == pwm_timer_pkg::chan1_compare_addr) begin
        next_s.compare[1][15:8] = writedata[15:8];
      end
    end
    // remember which pair software filled last, for the linked hand-over
    if ((wr_lo | wr_hi) && address == pwm_timer_pkg::chan0_compare_addr) begin
      next_s.last_written = 1'b0;
    end else if ((wr_lo | wr_hi) && address == pwm_timer_pkg::chan1_compare_addr) begin
      next_s.last_written = 1'b1;
    end

    // linked pair hand-over happens only at a wrap, so a fresh width written
    // to the pair not in control never cuts into the running period
    if (!linked) begin
      next_s.active_sel   = 1'b0;
      next_s.last_written = 1'b0;
    end else if (wrap) begin
      next_s.active_sel = s.last_written;
    end

    // pin: wrap toggle first, compare action after it
    next_s.pin = s.pin;
    if (wrap && s.ctrl[0][pwm_timer_pkg::toggle_on_wrap_pos]) begin
      next_s.pin = ~s.pin;
    end
    if (match[0]) begin
      if (els == pwm_timer_pkg::els_clear) begin
        next_s.pin = 1'b0;
      end else if (els == pwm_timer_pkg::els_set) begin
        next_s.pin = 1'b1;
      end else if (els == pwm_timer_pkg::els_toggle) begin
        next_s.pin = ~next_s.pin;
      end
    end
    if (s.ctrl[0][pwm_timer_pkg::full_duty_pos]
        && !s.ctrl[0][pwm_timer_pkg::toggle_on_wrap_pos]) begin
      next_s.pin_out = 1'b1;
    end else begin
      next_s.pin_out = next_s.pin;
    end
    next_s.pin_en = chan_on[0] & (els != 2'h0);

    // event flags: set after clear so a coincident event survives
    // a fresh event between the read and the write cancels the pending clear
    if (wrap) begin
      next_s.wrap_flag = 1'b1;
      next_s.wrap_arm  = 1'b0;
    end
    if (match[0]) begin
      next_s.event_flag[0] = 1'b1;
      next_s.event_arm[0]  = 1'b0;
    end
    if (match[1]) begin
      next_s.event_flag[1] = 1'b1;
      next_s.event_arm[1]  = 1'b0;
    end

    // stop freezes count, pin and hand-over select, but a counter reset write still clears the count; the bus side stays as written
    if (stop_mode) begin
      next_s.count      = counter_clear ? pwm_timer_pkg::counter_reset : s.count;
      next_s.pin        = s.pin;
      next_s.pin_out    = s.pin_out;
      next_s.active_sel = s.active_sel;
    end

    next_s.wrap_req = next_s.wrap_flag & next_s.wrap_irq_enable;
    next_s.chan_req = next_s.event_flag & next_s.irq_enable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s                <= '0;
      s.bus            <= pwm_timer_pkg::bus_idle;
      s.halt_count_bit <= pwm_timer_pkg::halt_count_reset;
      s.prescale       <= pwm_timer_pkg::prescale_reset;
      s.count          <= pwm_timer_pkg::counter_reset;
      s.period_limit   <= pwm_timer_pkg::period_limit_reset;
      s.compare[0]     <= pwm_timer_pkg::compare_reset;
      s.compare[1]     <= pwm_timer_pkg::compare_reset;
    end else begin
      s <= next_s;
    end
  end

  assign readdata              = s.rdata;
  assign channel_output_pin    = s.pin_out;
  assign channel_output_enable = s.pin_en;
  assign wrap_irq              = s.wrap_req;
  assign channel_irq           = s.chan_req;
  assign wake_request          = s.wrap_req | (|s.chan_req);

endmodule

/* test/buffered_compare_pwm_timer_chk.sv */
/*
  port checker for the counter unit: bus answer, low-power modes, requests.
  assumes one clock domain; bound from the bench top file.
*/
`timescale 1ns/1ps
module buffered_compare_pwm_timer_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        ext_clock_pin,
  input wire logic        channel_output_pin,
  input wire logic        channel_output_enable,
  input wire logic        wrap_irq,
  input wire logic [1:0]  channel_irq,
  input wire logic        wake_request
);
  wire logic main_wr = write && address == pwm_timer_pkg::main_status_control_addr;
  wire logic ctl_wr  = write && address == pwm_timer_pkg::chan0_status_control_addr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer took more than one wait state");
  a_idle_ready: assert property (!read && !write |-> !waitrequest)
    else $error("waitrequest high without a request");
  a_wait_reads_zero: assert property (
    wait_mode && $past(wait_mode) && read && !waitrequest |-> readdata == 32'h0000_0000)
    else $error("register read in wait mode returned data");
  a_wake_follows: assert property (
    wrap_irq || channel_irq != 2'h0 |-> ##[0:1] wake_request)
    else $error("request without wake");
  a_stop_holds_pin: assert property (
    stop_mode [*4] |-> $stable(channel_output_pin))
    else $error("pin moved in stop mode");
  a_stop_no_wrap: assert property (
    $rose(wrap_irq) |-> !($past(stop_mode) && $past(stop_mode, 2) && $past(stop_mode, 3)
    && $past(stop_mode, 4)))
    else $error("wrap request while stopped");
  a_wrap_clear_cause: assert property (
    $fell(wrap_irq) |-> $past(rst) || $past(rst, 2) || $past(main_wr, 2) || $past(main_wr, 3))
    else $error("wrap request dropped without a write");
  a_chan_clear_cause: assert property (
    $fell(channel_irq[0]) |-> $past(rst) || $past(rst, 2) || $past(ctl_wr, 2)
    || $past(ctl_wr, 3))
    else $error("channel request dropped without a write");
  a_enable_by_write: assert property (
    $changed(channel_output_enable) |-> $past(rst) || $past(ctl_wr) || $past(ctl_wr, 2)
    || $past(ctl_wr, 3))
    else $error("pin enable changed without a control write");
endmodule

/* test/pwm_load.sv */
/*
  load on the channel pin: measures high time and period between rises.
  assumes the pin is sampled on the bench clock.
*/
`timescale 1ns/1ps
module pwm_load (
  input  wire logic clk,
  input  wire logic pin,
  input  wire logic enable,
  output int        high_len,
  output int        period_len,
  output int        rises
);
  int   hc = 0;
  int   pc = 0;
  logic last = 1'b0;
  // an undriven pin reads low: the load pulls the line down
  wire logic level = pin & enable;
  initial begin
    high_len = 0;
    period_len = 0;
    rises = 0;
  end
  always @(posedge clk) begin
    last <= level;
    if (level && !last) begin
      high_len   <= hc;
      period_len <= pc;
      rises      <= rises + 1;
      hc         <= 1;
      pc         <= 1;
    end else begin
      hc <= hc + int'(level);
      pc <= pc + 1;
    end
  end
endmodule

/* test/buffered_compare_pwm_timer_tb.sv */
/*
  bench for the counter unit: avalon register traffic, pwm shapes, flags,
  wait and stop modes. assumes the load model and the checker file.
*/
`timescale 1ns/1ps
module buffered_compare_pwm_timer_tb;
  localparam logic [4:0] a_main = pwm_timer_pkg::main_status_control_addr;
  localparam logic [4:0] a_cnt  = pwm_timer_pkg::counter_value_addr;
  localparam logic [4:0] a_per  = pwm_timer_pkg::period_limit_addr;
  localparam logic [4:0] a_ctl0 = pwm_timer_pkg::chan0_status_control_addr;
  localparam logic [4:0] a_cmp0 = pwm_timer_pkg::chan0_compare_addr;
  localparam logic [4:0] a_ctl1 = pwm_timer_pkg::chan1_status_control_addr;
  localparam logic [4:0] a_cmp1 = pwm_timer_pkg::chan1_compare_addr;
  logic        clk = 1'b0;
  logic        rst, read, write, wait_mode, stop_mode, waitrequest;
  logic        pin, pin_en, wrap_irq, wake;
  logic [1:0]  chan_irq;
  logic [3:0]  byteenable;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, q, c0;
  int          failures, samples_checked, high_len, period_len, rises;

  always #20 clk = ~clk;

  buffered_compare_pwm_timer i_buffered_compare_pwm_timer (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .ext_clock_pin(1'b0),
    .channel_output_pin(pin), .channel_output_enable(pin_en), .wrap_irq(wrap_irq),
    .channel_irq(chan_irq), .wake_request(wake));
  pwm_load i_pwm_load (.clk(clk), .pin(pin), .enable(pin_en), .high_len(high_len),
    .period_len(period_len), .rises(rises));

  task final_report();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low, then releases it
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: bus answer timed out", $time);
      final_report();
    end
    @(posedge clk);
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task rd(input logic [4:0] a);
    acc(1'b0, a, 32'h0000_0000);
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // waits for n more pin rises, or for the wrap request when n is zero
  task wait_for(input int n);
    int r0, k;
    r0 = rises;
    k = 0;
    while ((n > 0 ? rises < r0 + n : wrap_irq !== 1'b1) && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 4000) begin
      failures++;
      $display("mismatch at %0t: pin or request wait timed out", $time);
      final_report();
    end
  endtask

  task t_reset();
    rd(a_main);
    check(q, 32'h0000_0020);
    rd(a_per);
    check(q, 32'h0000_ffff);
    wr(5'h1c, 32'h0000_00ff);
    rd(5'h1c);
    check(q, 32'h0000_0000);
    $display("reset values done");
  endtask

  task pwm_case(input logic [31:0] ctl, input logic [31:0] cmp, input int hi);
    wr(a_main, 32'h0000_0030);
    wr(a_per, 32'h0000_00ff);
    wr(a_cmp0, cmp);
    wr(a_ctl0, ctl);
    wr(a_main, 32'h0000_0000);
    wait_for(3);
    check(32'(high_len), 32'(hi));
    check(32'(period_len), 32'h0000_0100);
    $display("pwm case %h/%h done", ctl[7:0], cmp[7:0]);
  endtask

  // longer width written just after the wrap, shorter one after the compare
  task t_resize();
    wait_for(1);
    wr(a_cmp0, 32'h0000_00c0);
    wait_for(2);
    check(32'(high_len), 32'h0000_00c0);
    wait_cyc(200);
    wr(a_cmp0, 32'h0000_0040);
    wait_for(2);
    check(32'(high_len), 32'h0000_0040);
    $display("unbuffered resize done");
  endtask

  task t_levels();
    int r0;
    wr(a_ctl0, 32'h0000_0018);
    wait_cyc(300);
    r0 = rises;
    wait_cyc(600);
    check(32'(rises), 32'(r0));
    check(pin, 32'h0000_0000);
    wr(a_ctl0, 32'h0000_0019);
    wait_cyc(300);
    check(pin, 32'h0000_0001);
    $display("zero and full duty done");
  endtask

  task t_linked();
    wr(a_main, 32'h0000_0030);
    wr(a_cmp0, 32'h0000_0040);
    wr(a_ctl0, 32'h0000_002a);
    wr(a_ctl1, 32'h0000_000e);
    wr(a_main, 32'h0000_0000);
    wait_for(3);
    check(32'(high_len), 32'h0000_0040);
    wr(a_cmp1, 32'h0000_0020);
    wait_for(3);
    check(32'(high_len), 32'h0000_0020);
    wr(a_cmp0, 32'h0000_00c0);
    wait_for(3);
    check(32'(high_len), 32'h0000_00c0);
    $display("linked pair done");
  endtask

  task t_flags();
    wr(a_main, 32'h0000_0040);
    wait_for(0);
    check(wake, 32'h0000_0001);
    wr(a_main, 32'h0000_0060);
    wait_cyc(3);
    check(wrap_irq, 32'h0000_0001);
    rd(a_main);
    check(q, 32'h0000_00e0);
    wr(a_main, 32'h0000_0060);
    wait_cyc(3);
    check(wrap_irq, 32'h0000_0000);
    wr(a_ctl0, 32'h0000_001a);
    wait_cyc(3);
    check(chan_irq, 32'h0000_0000);
    wr(a_ctl0, 32'h0000_005a);
    wait_cyc(3);
    check(chan_irq, 32'h0000_0001);
    rd(a_ctl0);
    check(q, 32'h0000_00da);
    wr(a_ctl0, 32'h0000_005a);
    wait_cyc(3);
    check(chan_irq, 32'h0000_0000);
    wr(a_ctl1, 32'h0000_0050);
    wr(a_main, 32'h0000_0000);
    wait_cyc(300);
    check(chan_irq[1], 32'h0000_0001);
    $display("flags done");
  endtask

  task t_lowpower();
    wr(a_main, 32'h0000_0040);
    wait_mode <= 1'b1;
    rd(a_per);
    check(q, 32'h0000_0000);
    wr(a_per, 32'h0000_0010);
    wait_for(0);
    check(wake, 32'h0000_0001);
    wait_mode <= 1'b0;
    rd(a_per);
    check(q, 32'h0000_00ff);
    rd(a_main);
    wait_cyc(300);
    wr(a_main, 32'h0000_0040);
    wait_cyc(3);
    check(wrap_irq, 32'h0000_0001);
    stop_mode <= 1'b1;
    wait_cyc(4);
    rd(a_cnt);
    c0 = q;
    wait_cyc(40);
    rd(a_cnt);
    check(q, c0);
    stop_mode <= 1'b0;
    wait_cyc(4);
    rd(a_cnt);
    check(q !== c0, 32'h0000_0001);
    $display("wait and stop done");
  endtask

  task t_halt();
    wr(a_main, 32'h0000_0020);
    rd(a_cnt);
    c0 = q;
    wait_cyc(20);
    rd(a_cnt);
    check(q, c0);
    wr(a_main, 32'h0000_0030);
    rd(a_cnt);
    check(q, 32'h0000_0000);
    rd(a_main);
    check(q[5:4], 32'h0000_0002);
    $display("halt and counter reset done");
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    pwm_case(32'h0000_001a, 32'h0000_0080, 128);
    pwm_case(32'h0000_001a, 32'h0000_0040, 64);
    t_resize();
    pwm_case(32'h0000_001e, 32'h0000_0040, 192);
    t_levels();
    t_linked();
    t_flags();
    t_lowpower();
    t_halt();
    final_report();
  end
endmodule

bind buffered_compare_pwm_timer buffered_compare_pwm_timer_chk i_buffered_compare_pwm_timer_chk (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .ext_clock_pin(ext_clock_pin), .channel_output_pin(channel_output_pin),
  .channel_output_enable(channel_output_enable), .wrap_irq(wrap_irq),
  .channel_irq(channel_irq), .wake_request(wake_request));
